// ---- src/cct16_cfg.svh ----
// Purpose: Constants for the 16-bit capture/compare timer
// Assumes: Byte-wide register port, 250 MHz core clock
// Notes: Definitions only
`ifndef CCT16_CFG_SVH
`define CCT16_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CCT_OFF_CTRL 8'h12
`define CCT_OFF_STAT 8'h13
`define CCT_OFF_CAPH 8'h14
`define CCT_OFF_CAPL 8'h15
`define CCT_OFF_CMPH 8'h16
`define CCT_OFF_CMPL 8'h17
`define CCT_OFF_CNTH 8'h18
`define CCT_OFF_CNTL 8'h19
`define CCT_OFF_ALTH 8'h1A
`define CCT_OFF_ALTL 8'h1B

// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define CCT_BIT_CAP_IE 7
`define CCT_BIT_CMP_IE 6
`define CCT_BIT_OVF_IE 5
`define CCT_BIT_EDGE 1
`define CCT_BIT_LEVEL 0
`define CCT_CNT_PRESET 16'hFFFC
`define CCT_CNT_MAX 16'hFFFF
`define CCT_PRESC_LAST 2'h3
`define CCT_STARTUP_DEF 4064

`endif

// ---- src/cct16_pkg.sv ----
// Purpose: Types for the 16-bit capture/compare timer
// Assumes: Used with cct16_cfg.svh
// Notes: Nothing is imported
package cct16_pkg;

	typedef struct packed {
		logic capture_irq_enable;
		logic compare_irq_enable;
		logic overflow_irq_enable;
		logic capture_edge_select;
		logic compare_output_level;
	} cct16_ctrl_s;

	typedef struct packed {
		logic capture_flag;
		logic compare_flag;
		logic overflow_flag;
	} cct16_flags_s;

	typedef enum logic [1:0] {
		CCT16_ST_STARTUP,
		CCT16_ST_RUN
	} cct16_state_e;

endpackage

// ---- src/cct16_flag.sv ----
// Purpose: One timer status flag with its two-step clear
// Assumes: Same clock domain as the timer
// Notes: Set wins over clear in the same cycle
`timescale 1ns/1ps
`include "cct16_cfg.svh"

module cct16_flag (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic set_i,
	input wire logic stat_rd_i,
	input wire logic low_acc_i,
	output logic flag_o
);

	logic armed_ff;

	// ----------------------------------------
	// Arming by status read, clear by low access
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			armed_ff <= 1'b0;
		end else if (stat_rd_i && flag_o) begin
			armed_ff <= 1'b1;
		end else if (low_acc_i || !flag_o) begin
			armed_ff <= 1'b0;
		end
	end

	// Flags are unaffected by reset in the part; start clear for a defined state
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			flag_o <= 1'b0;
		end else if (set_i) begin
			flag_o <= 1'b1;
		end else if (low_acc_i && armed_ff) begin
			flag_o <= 1'b0;
		end
	end

	set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
		set_i |=> flag_o) else $error("flag not set after event");
	clear_needs_arm_a: assert property (@(posedge clk_i) disable iff (rst_i)
		flag_o && !armed_ff && !set_i |=> flag_o) else $error("flag cleared unarmed");

endmodule

// ---- src/cct16_timer.sv ----
// Purpose: 16-bit capture/compare timer with byte-wide register port
// Assumes: Single 250 MHz clock; rd/wr strobes are one-cycle pulses
// Notes: Read data is registered, valid the cycle after the read strobe
`timescale 1ns/1ps
`include "cct16_cfg.svh"

module cct16_timer #(
	parameter int STARTUP_CYCLES = `CCT_STARTUP_DEF
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	input wire logic capture_input_pin_i,
	output logic compare_output_pin_o,
	output logic irq_o
);

	cct16_pkg::cct16_ctrl_s ctrl_ff;
	cct16_pkg::cct16_flags_s flags;
	cct16_pkg::cct16_state_e state_ff;
	logic [1:0] presc_ff;
	logic tick;
	logic [15:0] cnt_ff;
	logic [15:0] cap_ff;
	logic [15:0] cmp_ff;
	logic [7:0] lowbuf_ff;
	logic lowheld_ff;
	logic cmp_inhibit_ff;
	logic cap_inhibit_ff;
	logic [31:0] start_ff;
	logic [2:0] pin_ff;
	logic edge_seen;
	logic cmp_match;
	logic stat_rd;
	logic [7:0] nxt_rdata;

	// ----------------------------------------
	// Startup delay and prescaler
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff <= cct16_pkg::CCT16_ST_STARTUP;
			start_ff <= 32'h0000_0000;
		end else begin
			case (state_ff)
				cct16_pkg::CCT16_ST_STARTUP: begin
					if (start_ff >= 32'(STARTUP_CYCLES - 1)) begin
						state_ff <= cct16_pkg::CCT16_ST_RUN;
					end else begin
						start_ff <= start_ff + 32'h0000_0001;
					end
				end
				cct16_pkg::CCT16_ST_RUN: begin
					state_ff <= cct16_pkg::CCT16_ST_RUN;
				end
				default: begin
					state_ff <= cct16_pkg::CCT16_ST_STARTUP;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			presc_ff <= 2'h0;
		end else if (state_ff == cct16_pkg::CCT16_ST_RUN) begin
			presc_ff <= presc_ff + 2'h1;
		end
	end

	assign tick = (state_ff == cct16_pkg::CCT16_ST_RUN) && (presc_ff == `CCT_PRESC_LAST);

	// ----------------------------------------
	// Free-running counter
	// ----------------------------------------
	// No write path exists: the counter is read-only
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_ff <= `CCT_CNT_PRESET;
		end else if (tick) begin
			cnt_ff <= cnt_ff + 16'h0001;
		end
	end

	// ----------------------------------------
	// Capture path
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_ff <= 3'h0;
		end else begin
			pin_ff <= {pin_ff[1:0], capture_input_pin_i};
		end
	end

	// Only stages 1 and 2 are looked at; stage 0 feeds stage 1 alone
	assign edge_seen = ctrl_ff.capture_edge_select ? (pin_ff[1] && !pin_ff[2])
		: (!pin_ff[1] && pin_ff[2]);

	// Capture register is not reset; held at zero here only for a defined start
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cap_ff <= 16'h0000;
		end else if (edge_seen && !cap_inhibit_ff) begin
			cap_ff <= cnt_ff;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cap_inhibit_ff <= 1'b0;
		end else if (rd_i && addr_i == `CCT_OFF_CAPH) begin
			cap_inhibit_ff <= 1'b1;
		end else if (rd_i && addr_i == `CCT_OFF_CAPL) begin
			cap_inhibit_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// Compare path
	// ----------------------------------------
	// Compare bytes survive reset, so they start unknown until software writes them
	always_ff @(posedge clk_i) begin
		if (wr_i && addr_i == `CCT_OFF_CMPH) begin
			cmp_ff[15:8] <= wdata_i;
		end else if (wr_i && addr_i == `CCT_OFF_CMPL) begin
			cmp_ff[7:0] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cmp_inhibit_ff <= 1'b0;
		end else if (wr_i && addr_i == `CCT_OFF_CMPH) begin
			cmp_inhibit_ff <= 1'b1;
		end else if (wr_i && addr_i == `CCT_OFF_CMPL) begin
			cmp_inhibit_ff <= 1'b0;
		end
	end

	assign cmp_match = tick && !cmp_inhibit_ff && (cnt_ff == cmp_ff);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			compare_output_pin_o <= 1'b0;
		end else if (cmp_match) begin
			compare_output_pin_o <= ctrl_ff.compare_output_level;
		end
	end

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_ff <= '0;
		end else if (wr_i && addr_i == `CCT_OFF_CTRL) begin
			ctrl_ff.capture_irq_enable <= wdata_i[`CCT_BIT_CAP_IE];
			ctrl_ff.compare_irq_enable <= wdata_i[`CCT_BIT_CMP_IE];
			ctrl_ff.overflow_irq_enable <= wdata_i[`CCT_BIT_OVF_IE];
			ctrl_ff.capture_edge_select <= wdata_i[`CCT_BIT_EDGE];
			ctrl_ff.compare_output_level <= wdata_i[`CCT_BIT_LEVEL];
		end
	end

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	assign stat_rd = rd_i && (addr_i == `CCT_OFF_STAT);

	cct16_flag u_cap_flag (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.set_i(edge_seen && !cap_inhibit_ff),
		.stat_rd_i(stat_rd),
		.low_acc_i(rd_i && addr_i == `CCT_OFF_CAPL),
		.flag_o(flags.capture_flag)
	);

	cct16_flag u_cmp_flag (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.set_i(cmp_match),
		.stat_rd_i(stat_rd),
		.low_acc_i((rd_i || wr_i) && addr_i == `CCT_OFF_CMPL),
		.flag_o(flags.compare_flag)
	);

	cct16_flag u_ovf_flag (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.set_i(tick && cnt_ff == `CCT_CNT_MAX),
		.stat_rd_i(stat_rd),
		.low_acc_i((rd_i || wr_i) && addr_i == `CCT_OFF_CNTL),
		.flag_o(flags.overflow_flag)
	);

	assign irq_o = (flags.capture_flag && ctrl_ff.capture_irq_enable)
		|| (flags.compare_flag && ctrl_ff.compare_irq_enable)
		|| (flags.overflow_flag && ctrl_ff.overflow_irq_enable);

	// ----------------------------------------
	// Low-byte buffer and read data
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			lowheld_ff <= 1'b0;
			lowbuf_ff <= 8'h00;
		end else if (rd_i && (addr_i == `CCT_OFF_CNTH || addr_i == `CCT_OFF_ALTH)) begin
			if (!lowheld_ff) begin
				lowbuf_ff <= cnt_ff[7:0];
			end
			lowheld_ff <= 1'b1;
		end else if (rd_i && (addr_i == `CCT_OFF_CNTL || addr_i == `CCT_OFF_ALTL)) begin
			lowheld_ff <= 1'b0;
		end
	end

	always_comb begin
		nxt_rdata = 8'h00;
		case (addr_i)
			`CCT_OFF_CTRL: nxt_rdata = {ctrl_ff.capture_irq_enable,
				ctrl_ff.compare_irq_enable, ctrl_ff.overflow_irq_enable, 3'h0,
				ctrl_ff.capture_edge_select, ctrl_ff.compare_output_level};
			`CCT_OFF_STAT: nxt_rdata = {flags, 5'h00};
			`CCT_OFF_CAPH: nxt_rdata = cap_ff[15:8];
			`CCT_OFF_CAPL: nxt_rdata = cap_ff[7:0];
			`CCT_OFF_CMPH: nxt_rdata = cmp_ff[15:8];
			`CCT_OFF_CMPL: nxt_rdata = cmp_ff[7:0];
			`CCT_OFF_CNTH, `CCT_OFF_ALTH: nxt_rdata = cnt_ff[15:8];
			`CCT_OFF_CNTL, `CCT_OFF_ALTL: begin
				nxt_rdata = lowheld_ff ? lowbuf_ff : cnt_ff[7:0];
			end
			default: nxt_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			rdata_o <= nxt_rdata;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	tick_spacing_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tick |=> !tick [*3] ##1 tick) else $error("tick spacing not four");
	count_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tick |=> cnt_ff == $past(cnt_ff) + 16'h0001) else $error("counter step wrong");
	count_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!tick |=> $stable(cnt_ff)) else $error("counter moved off tick");
	capture_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
		edge_seen && !cap_inhibit_ff |=> cap_ff == $past(cnt_ff)) else $error("capture missed");
	compare_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cmp_match |=> compare_output_pin_o == $past(ctrl_ff.compare_output_level))
		else $error("compare pin wrong");
	compare_inhibit_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_i && addr_i == `CCT_OFF_CMPH |=> !cmp_match) else $error("match while inhibited");
	overflow_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tick && cnt_ff == `CCT_CNT_MAX |=> flags.overflow_flag && cnt_ff == 16'h0000)
		else $error("overflow not flagged");
	mirror_keeps_a: assert property (@(posedge clk_i) disable iff (rst_i)
		flags.overflow_flag && !wr_i && addr_i == `CCT_OFF_ALTL |=> flags.overflow_flag)
		else $error("mirror read cleared overflow");
	irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_o |-> (flags & {ctrl_ff.capture_irq_enable, ctrl_ff.compare_irq_enable,
		ctrl_ff.overflow_irq_enable}) != 3'h0) else $error("irq without enabled flag");
	buffer_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		lowheld_ff && !(rd_i && (addr_i == `CCT_OFF_CNTL || addr_i == `CCT_OFF_ALTL))
		|=> $stable(lowbuf_ff)) else $error("low buffer changed");

	cap_seen_c: cover property (@(posedge clk_i) disable iff (rst_i) edge_seen);
	cmp_seen_c: cover property (@(posedge clk_i) disable iff (rst_i) cmp_match);
	wrap_seen_c: cover property (@(posedge clk_i) disable iff (rst_i)
		tick && cnt_ff == `CCT_CNT_MAX);
	irq_seen_c: cover property (@(posedge clk_i) disable iff (rst_i) irq_o);

endmodule

// ---- test/capture_compare_timer16_tb.sv ----
// Purpose: Self-checking bench for the 16-bit capture/compare timer
// Assumes: Startup delay shortened to 4 clocks; inputs change on the falling edge
// Notes: Each register access takes two cycles so strobes never toggle twice at once
`timescale 1ns/1ps

module capture_compare_timer16_tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic rd_i = 1'b0;
	logic wr_i = 1'b0;
	logic [7:0] wdata_i = 8'h00;
	logic [7:0] rdata_o;
	logic cap_pin = 1'b0;
	logic compare_output_pin_o;
	logic irq_o;
	int bad_count = 0;
	int tests_run = 0;
	logic [7:0] d;
	logic [15:0] v;
	logic [15:0] t;
	logic ok;

	always #2 clk_i = ~clk_i;

	cct16_timer #(.STARTUP_CYCLES(4)) DUT (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.addr_i(addr_i),
		.rd_i(rd_i),
		.wr_i(wr_i),
		.wdata_i(wdata_i),
		.rdata_o(rdata_o),
		.capture_input_pin_i(cap_pin),
		.compare_output_pin_o(compare_output_pin_o),
		.irq_o(irq_o)
	);

	// ----------------------------------------
	// Shared helpers
	// ----------------------------------------
	task automatic give_verdict();
		$display("Checks run %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] w);
		addr_i = a;
		wdata_i = w;
		wr_i = 1'b1;
		@(negedge clk_i);
		wr_i = 1'b0;
		@(negedge clk_i);
	endtask

	task automatic rd(input logic [7:0] a);
		addr_i = a;
		rd_i = 1'b1;
		@(negedge clk_i);
		rd_i = 1'b0;
		d = rdata_o;
		@(negedge clk_i);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string m);
		rd(a);
		chk({8'h00, d}, {8'h00, e}, m);
	endtask

	// High byte first, so the low byte comes from the frozen buffer
	task automatic rdpair(input logic [7:0] a);
		rd(a);
		v[15:8] = d;
		rd(a + 8'h01);
		v[7:0] = d;
	endtask

	task automatic wait_sig(input bit pick_irq, input logic e, input int n);
		int i = 0;
		while (i < n && (pick_irq ? irq_o : compare_output_pin_o) !== e) begin
			@(negedge clk_i);
			i++;
		end
		if (i == n) begin
			bad_count++;
			$display("CHECK FAILED at %0t: wait ran out", $time);
			give_verdict();
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		wr(8'h16, 8'h00);
		wr(8'h17, 8'h00);
		rdc(8'h18, 8'hFF, "preset high");
		// Frozen in the low buffer; the counter has not had its first tick since startup ended
		rdc(8'h19, 8'hFC, "held through startup");
		wr(8'h19, 8'h00);
		rdc(8'h1B, 8'hFD, "counter write ignored");
		rdc(8'h1A, 8'hFF, "mirror high");
		rdc(8'h1B, 8'hFE, "mirror low frozen");
		rdc(8'h13, 8'h00, "status reset");
		rdc(8'h12, 8'h00, "control reset");
		wr(8'h12, 8'h20);
		rdc(8'h1C, 8'h00, "unmapped read");
	endtask

	task automatic t_prescale();
		rd(8'h1B);
		t[7:0] = d;
		repeat (14) @(negedge clk_i);
		rd(8'h1B);
		chk({8'h00, d - t[7:0]}, 16'h0004, "four ticks in sixteen clocks");
	endtask

	// Compare register was written to zero, so the count after the wrap also matches
	task automatic t_overflow();
		wait_sig(1'b1, 1'b1, 100);
		rdc(8'h13, 8'h60, "wrap flags");
		rd(8'h1B);
		rdc(8'h13, 8'h60, "mirror keeps overflow");
		rd(8'h19);
		rdc(8'h13, 8'h40, "overflow cleared");
		chk({15'h0000, irq_o}, 16'h0000, "disabled flag no irq");
	endtask

	task automatic t_compare();
		wr(8'h12, 8'h41);
		chk({15'h0000, irq_o}, 16'h0001, "compare irq enabled");
		rdpair(8'h1A);
		t = v + 16'h0018;
		wr(8'h16, t[15:8]);
		rd(8'h13);
		wr(8'h17, t[7:0]);
		chk({15'h0000, irq_o}, 16'h0000, "compare flag cleared");
		rdc(8'h16, t[15:8], "compare high readback");
		rdc(8'h17, t[7:0], "compare low readback");
		wait_sig(1'b0, 1'b1, 300);
		chk({15'h0000, irq_o}, 16'h0001, "compare irq");
		wr(8'h12, 8'h40);
		rdpair(8'h1A);
		t = v + 16'h0018;
		// Low byte first, so only the high write can hold the match off
		wr(8'h17, t[7:0]);
		wr(8'h16, t[15:8]);
		repeat (140) @(negedge clk_i);
		chk({15'h0000, compare_output_pin_o}, 16'h0001, "high write inhibits");
		rdpair(8'h1A);
		t = v + 16'h0018;
		wr(8'h16, t[15:8]);
		wr(8'h17, t[7:0]);
		// Flag is still set from the first match, status was not read since
		wait_sig(1'b0, 1'b0, 300);
		// Low byte one below the matched count keeps the next match far away
		wr(8'h17, t[7:0] - 8'h01);
		rdc(8'h16, t[15:8], "other byte kept");
		rdc(8'h13, 8'h40, "compare flag set");
		rdc(8'h13, 8'h40, "flag before clear");
		rd(8'h17);
		rdc(8'h13, 8'h00, "read of low clears");
		chk({15'h0000, irq_o}, 16'h0000, "irq gone");
	endtask

	task automatic t_capture();
		wr(8'h12, 8'h82);
		rdpair(8'h1A);
		t = v;
		cap_pin = 1'b1;
		repeat (6) @(negedge clk_i);
		rdc(8'h13, 8'h80, "rising capture");
		chk({15'h0000, irq_o}, 16'h0001, "capture irq");
		rdpair(8'h14);
		ok = (v - t) <= 16'h0003;
		chk({15'h0000, ok}, 16'h0001, "captured count");
		rdc(8'h13, 8'h00, "capture flag cleared");
		cap_pin = 1'b0;
		repeat (6) @(negedge clk_i);
		rdc(8'h13, 8'h00, "falling ignored");
		wr(8'h12, 8'h00);
		cap_pin = 1'b1;
		repeat (6) @(negedge clk_i);
		rdc(8'h13, 8'h00, "rising ignored");
		cap_pin = 1'b0;
		repeat (6) @(negedge clk_i);
		rdc(8'h13, 8'h80, "falling capture");
		chk({15'h0000, irq_o}, 16'h0000, "capture irq masked");
	endtask

	// A reset in mid-run keeps the compare bytes and presets the counter again
	task automatic t_retain();
		wr(8'h16, 8'hA5);
		wr(8'h17, 8'h5A);
		rst_i = 1'b1;
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		rdc(8'h16, 8'hA5, "compare high kept over reset");
		rdc(8'h17, 8'h5A, "compare low kept over reset");
		rdc(8'h18, 8'hFF, "preset after reset");
		rdc(8'h19, 8'hFC, "held after reset");
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (8) @(negedge clk_i);
		rst_i = 1'b0;
		t_reset();
		t_prescale();
		t_overflow();
		t_compare();
		t_capture();
		t_retain();
		give_verdict();
	end
endmodule
